//--- logic/mem_map_decoder.v
/*
 * processor memory map decoder: takes one access per cycle from the core
 * or a dma master and steers it to a first-level memory, the scratchpad,
 * a mapped register block, the sdram window or an async bank select.
 * assumes requesters hold no more than one access in flight and that
 * the other side samples the registered strobes one cycle after request.
 */
`timescale 1ns/100ps
`include "mem_map_defines.vh"

module mem_map_decoder #(
    parameter ROW_W = 13            // sdram row width
) (
    input  wire        mclk,          // 20 MHz system clock
    input  wire        resetn,        // synchronous reset, active low
    input  wire        ce,            // clock enable, freezes state when low
    input  wire        reqValid,      // access request strobe
    input  wire [31:0] reqAddr,       // byte address
    input  wire        reqWrite,      // write when high
    input  wire        reqSuper,      // requester in supervisor mode
    input  wire        reqDma,        // requester is a peripheral dma master
    input  wire        reqFetch,      // instruction fetch
    input  wire [1:0]  sdramSizeSel,  // 0:16M 1:64M 2:128M 3:512M
    input  wire        dCacheEnA,     // bank a upper half is cache
    input  wire        dCacheEnB,     // bank b upper half is cache
    input  wire        iCacheEn,      // instruction top 16K is cache
    input  wire        bootRom,       // boot strap pin, rom boot
    input  wire        busRequestInN, // external bus request, active low pin
    output reg         ackValid,      // access completed
    output reg         ackError,      // access refused or reserved
    output reg  [8:0]  selTarget,     // one-hot target select
    output reg  [3:0]  asyncBankSelN, // async bank selects, active low
    output reg         sdramRowHit,   // open row hit, no activate needed
    output reg  [1:0]  busWidthBytes, // external bus width, bytes
    output reg         busGranted,    // external pins released to other master
    output reg  [31:0] bootVector,    // execution start after reset
    output reg  [31:0] accessAddr     // address forwarded to target
);
    // sdram size decode, bytes
    reg [31:0] sdramBytes;
    always @* begin
        case (sdramSizeSel)
            2'h0:    sdramBytes = `SDRAM_MIN_BYTES;
            2'h1:    sdramBytes = 32'h04000000;
            2'h2:    sdramBytes = 32'h08000000;
            2'h3:    sdramBytes = `SDRAM_MAX_BYTES;
            default: sdramBytes = `SDRAM_MIN_BYTES;
        endcase
    end

    wire [3:0] target;
    wire [1:0] asyncBank;
    wire       cfgHalf;

    // one comparator tree for the whole flat space
    region_lookup uLookup (
        .addr       (reqAddr),
        .sdramBytes (sdramBytes),
        .target     (target),
        .asyncBank  (asyncBank),
        .cfgHalf    (cfgHalf)
    );

    // bus request pin passes three flops; act when the last two agree
    reg [2:0] brSync;
    reg       brActive;
    always @(posedge mclk) begin
        if (!resetn) begin
            brSync   <= 3'h7;
            brActive <= 1'b0;
        end else if (ce) begin
            brSync <= {brSync[1:0], busRequestInN};
            if (brSync[2] == brSync[1])
                brActive <= ~brSync[2];
        end
    end

    // access legality: register blocks need supervisor, dma sees reserved
    wire isRegBlk  = (target == `TGT_SYSREG) || (target == `TGT_COREREG);
    wire regRefuse = isRegBlk && (reqDma || !reqSuper);
    // instruction memory holds code; scratchpad and data banks hold data
    wire fetchBad  = reqFetch && (target != `TGT_IMEM) && (target != `TGT_SDRAM)
                     && (target != `TGT_ASYNC);
    // cache-configured top 16K parts are owned by the cache, not sram
    wire cacheBusy = cfgHalf && ((target == `TGT_DBANK_A && dCacheEnA) ||
                                 (target == `TGT_DBANK_B && dCacheEnB) ||
                                 (target == `TGT_IMEM && iCacheEn));
    // external accesses wait while another master owns the pins
    wire extTarget = (target == `TGT_SDRAM) || (target == `TGT_ASYNC);
    wire stall     = extTarget && brActive;
    wire refuse    = (target == `TGT_NONE) || regRefuse || fetchBad || cacheBusy;

    // sdram row address: 16-bit bus, bank bits 23:22 above the row bits, row bits 21:9 above the columns
    wire [1:0]       rowBank = reqAddr[23:22];
    wire [ROW_W-1:0] rowAddr = reqAddr[ROW_W+8:9];
    wire             rowHit;
    wire             sdramGo = reqValid && !refuse && !stall &&
                               (target == `TGT_SDRAM);

    row_tracker #(.ROW_W(ROW_W)) uRows (
        .mclk   (mclk),
        .resetn (resetn),
        .ce     (ce),
        .access (sdramGo),
        .bank   (rowBank),
        .row    (rowAddr),
        .rowHit (rowHit)
    );

    // flags a request stalled last cycle while the external pins are taken
    reg        pending;
    reg [31:0] next_accessAddr;
    always @* begin
        next_accessAddr = accessAddr;
        if (reqValid && !refuse && !stall)
            next_accessAddr = reqAddr;
    end

    // one-hot target from the decoded code
    reg [8:0] next_sel;
    always @* begin
        next_sel = 9'h000;
        if (reqValid && !refuse && !stall && target != `TGT_NONE)
            next_sel[target - 4'h1] = 1'b1;
    end

    // registered answer; reserved and refused accesses touch no target
    always @(posedge mclk) begin
        if (!resetn) begin
            ackValid      <= 1'b0;
            ackError      <= 1'b0;
            selTarget     <= 9'h000;
            asyncBankSelN <= 4'hf;
            sdramRowHit   <= 1'b0;
            accessAddr    <= 32'h00000000;
            pending       <= 1'b0;
        end else if (ce) begin
            ackValid      <= 1'b0;
            ackError      <= 1'b0;
            selTarget     <= next_sel;
            asyncBankSelN <= 4'hf;
            sdramRowHit   <= 1'b0;
            accessAddr    <= next_accessAddr;
            pending       <= reqValid && !refuse && stall;
            if (reqValid) begin
                if (refuse) begin
                    ackValid <= 1'b1;
                    ackError <= 1'b1;
                end else if (!stall) begin
                    ackValid <= 1'b1;
                    if (target == `TGT_ASYNC)
                        asyncBankSelN <= ~(4'h1 << asyncBank);
                    if (target == `TGT_SDRAM)
                        sdramRowHit <= rowHit;
                end
            end
        end
    end

    // static bus facts and bus grant state
    always @(posedge mclk) begin
        if (!resetn) begin
            busWidthBytes <= 2'h2;
            busGranted    <= 1'b0;
        end else if (ce) begin
            busWidthBytes <= 2'h2;
            busGranted    <= brActive && !pending;
        end
    end

    // boot vector caught by a clocked process after reset release
    reg bootCaught;
    always @(posedge mclk) begin
        if (!resetn) begin
            bootCaught <= 1'b0;
            bootVector <= 32'h00000000;
        end else if (ce && !bootCaught) begin
            bootCaught <= 1'b1;
            bootVector <= bootRom ? `BOOT_ROM_VECTOR : `ASYNC_BASE;
        end
    end
endmodule

//--- inc/mem_map_defines.vh
/*
 * address map constants for the processor memory map decoder: region bases,
 * limits, target codes and the boot vector.
 * assumes inclusion by bare name from the decoder files; definitions only.
 */
`ifndef MEM_MAP_DEFINES_VH
`define MEM_MAP_DEFINES_VH

// external region
`define SDRAM_BASE        32'h00000000
`define SDRAM_MIN_BYTES   32'h01000000
`define SDRAM_MAX_BYTES   32'h20000000
`define ASYNC_BASE        32'h20000000
`define ASYNC_BANK_BYTES  32'h00100000
`define ASYNC_END         32'h20400000
`define RESV_EXT_END      32'hef000000

// first-level data bank a and b
`define DBANK_A_BASE      32'hff800000
`define DBANK_A_CFG       32'hff804000
`define DBANK_A_END       32'hff808000
`define DBANK_B_BASE      32'hff900000
`define DBANK_B_CFG       32'hff904000
`define DBANK_B_END       32'hff908000

// first-level instruction memory
`define IMEM_BASE         32'hffa00000
`define IMEM_CFG          32'hffa10000
`define IMEM_END          32'hffa14000

// scratchpad and mapped register blocks
`define SCRATCH_BASE      32'hffb00000
`define SCRATCH_END       32'hffb01000
`define SYSREG_BASE       32'hffc00000
`define COREREG_BASE      32'hffe00000

// boot rom vector taken when boot strap selects rom
`define BOOT_ROM_VECTOR   32'hef000000

// target codes; the one-hot select bit is the code minus one
`define TGT_NONE          4'h0
`define TGT_SDRAM         4'h1
`define TGT_ASYNC         4'h2
`define TGT_DBANK_A       4'h3
`define TGT_DBANK_B       4'h4
`define TGT_IMEM          4'h5
`define TGT_SCRATCH       4'h6
`define TGT_SYSREG        4'h7
`define TGT_COREREG       4'h8

// row tracker: four internal sdram banks
`define SDRAM_IBANKS      4
`endif

//--- logic/region_lookup.v
/*
 * combinational lookup of one 32-bit byte address into a target code,
 * an async bank number and a cache-capable flag.
 * assumes the defines header and a programmed sdram size in bytes.
 */
`timescale 1ns/100ps
`include "mem_map_defines.vh"

module region_lookup (
    input  wire [31:0] addr,        // byte address
    input  wire [31:0] sdramBytes,  // usable sdram size
    output reg  [3:0]  target,      // decoded target code
    output reg  [1:0]  asyncBank,   // async bank number
    output reg         cfgHalf      // top 16K sram/cache part
);
    // single flat space; anything not matched falls to reserved
    always @* begin
        target    = `TGT_NONE;
        asyncBank = 2'h0;
        cfgHalf   = 1'b0;
        if (addr < sdramBytes) begin
            target = `TGT_SDRAM;
        end else if (addr >= `ASYNC_BASE && addr < `ASYNC_END) begin
            target    = `TGT_ASYNC;
            asyncBank = addr[21:20];
        end else if (addr >= `DBANK_A_BASE && addr < `DBANK_A_END) begin
            target  = `TGT_DBANK_A;
            cfgHalf = (addr >= `DBANK_A_CFG);
        end else if (addr >= `DBANK_B_BASE && addr < `DBANK_B_END) begin
            target  = `TGT_DBANK_B;
            cfgHalf = (addr >= `DBANK_B_CFG);
        end else if (addr >= `IMEM_BASE && addr < `IMEM_END) begin
            target  = `TGT_IMEM;
            cfgHalf = (addr >= `IMEM_CFG);
        end else if (addr >= `SCRATCH_BASE && addr < `SCRATCH_END) begin
            target = `TGT_SCRATCH;
        end else if (addr >= `COREREG_BASE) begin
            target = `TGT_COREREG;
        end else if (addr >= `SYSREG_BASE) begin
            target = `TGT_SYSREG;
        end
        // async end up to internal memory stays TGT_NONE
    end
endmodule

//--- logic/row_tracker.v
/*
 * open-row bookkeeping for the sdram window, one entry per internal bank.
 * assumes accesses arrive as one-cycle strobes on the system clock.
 */
`timescale 1ns/100ps
`include "mem_map_defines.vh"

module row_tracker #(
    parameter ROW_W = 13            // row address width
) (
    input  wire             mclk,     // system clock
    input  wire             resetn,   // synchronous reset, active low
    input  wire             ce,       // clock enable
    input  wire             access,   // sdram access strobe
    input  wire [1:0]       bank,     // internal bank
    input  wire [ROW_W-1:0] row,      // row address
    output wire             rowHit    // row already open
);
    reg [`SDRAM_IBANKS-1:0] openValid;
    reg [ROW_W-1:0]         openRow [0:`SDRAM_IBANKS-1];

    assign rowHit = openValid[bank] && (openRow[bank] == row);

    // one open row per bank; a miss opens the new row
    genvar g;
    generate
        for (g = 0; g < `SDRAM_IBANKS; g = g + 1) begin : gBank
            always @(posedge mclk) begin
                if (!resetn) begin
                    openValid[g] <= 1'b0;
                    openRow[g]   <= {ROW_W{1'b0}};
                end else if (ce && access && bank == g) begin
                    openValid[g] <= 1'b1;
                    openRow[g]   <= row;
                end
            end
        end
    endgenerate
endmodule

//--- tb/mem_map_decoder_monitor.sv
/* checker for the memory map decoder ports.
   assumes a bind onto the decoder and one clock, mclk. */
`timescale 1ns/100ps
module mem_map_decoder_monitor (
    input wire        mclk,          // clock
    input wire        resetn,        // reset, low
    input wire        ce,            // enable
    input wire        reqValid,      // request
    input wire [31:0] reqAddr,       // address
    input wire        reqSuper,      // supervisor
    input wire        reqDma,        // dma master
    input wire        reqFetch,      // fetch
    input wire        busRequestInN, // bus request, low
    input wire        ackValid,      // ack
    input wire        ackError,      // error
    input wire [8:0]  selTarget,     // select
    input wire [3:0]  asyncBankSelN, // bank selects
    input wire        sdramRowHit,   // row hit
    input wire [31:0] accessAddr     // forwarded address
);
    // request taken at this edge
    wire req = ce && reqValid;
    default clocking @(posedge mclk); endclocking
    default disable iff (!resetn);
    AST_IDLE: assert property (ce && !reqValid |=> !ackValid)
        else $error("ack without request");
    AST_ONEHOT: assert property (ackValid && !ackError |-> $onehot(selTarget))
        else $error("select not one-hot");
    AST_NOSEL: assert property (ackError |-> selTarget == 9'h0 && &asyncBankSelN)
        else $error("refused access selected a target");
    AST_ASYNC: assert property (ackValid && selTarget[1] |->
        asyncBankSelN == ~(4'h1 << accessAddr[21:20]))
        else $error("wrong async bank select");
    AST_RESV: assert property (req && reqAddr >= 32'h20400000 && reqAddr < 32'hff800000
        |=> ackValid && ackError)
        else $error("reserved gap not refused");
    AST_PRIV: assert property (req && reqAddr >= 32'hffc00000 && (reqDma || !reqSuper)
        |=> ackValid && ackError)
        else $error("register block open to unprivileged");
    AST_SCRATCH: assert property (req && !reqFetch && reqAddr >= 32'hffb00000
        && reqAddr < 32'hffb01000 |=> selTarget[5])
        else $error("scratchpad not selected");
    // the pin must have been idle long enough for the synchroniser to settle
    AST_SDRAM: assert property (req && reqAddr < 32'h01000000 && busRequestInN
        && $past(busRequestInN, 4) |=> selTarget[0])
        else $error("low address not sent to sdram");
    AST_FWD: assert property (req ##1 (ackValid && !ackError) |-> accessAddr == $past(reqAddr))
        else $error("forwarded address differs");
    AST_ROWSEL: assert property (sdramRowHit |-> ackValid && selTarget[0])
        else $error("row hit outside sdram access");
    cover property (ackValid && selTarget[1]);
    cover property (ackValid && ackError);
    cover property (sdramRowHit);
    cover property (req && reqDma && reqAddr >= 32'hffc00000);
endmodule
bind mem_map_decoder mem_map_decoder_monitor mon_inst (.mclk, .resetn, .ce, .reqValid,
    .reqAddr, .reqSuper, .reqDma, .reqFetch, .busRequestInN, .ackValid, .ackError,
    .selTarget, .asyncBankSelN, .sdramRowHit, .accessAddr);

//--- tb/requester_model.sv
/* requester model: core or dma master issuing one access per cycle,
   and the outside master pulling the bus request pin.
   assumes calls at the falling edge of mclk. */
`timescale 1ns/100ps
module requester_model (
    output reg        reqValid,      // request
    output reg [31:0] reqAddr,       // address
    output reg        reqWrite,      // write
    output reg        reqSuper,      // supervisor
    output reg        reqDma,        // dma master
    output reg        reqFetch,      // fetch
    output reg        busRequestInN  // bus request, low
);
    initial begin
        {reqValid, reqWrite, reqSuper, reqDma, reqFetch} = 5'h0;
        reqAddr = 32'h0;
        busRequestInN = 1'b1;
    end
    // idle address lines flip so a stale value is never mistaken for a request
    task put(input v, input [31:0] a, input [3:0] f);
        begin
            reqValid = v;
            reqAddr = v ? a : ~reqAddr;
            {reqWrite, reqSuper, reqDma, reqFetch} = f;
        end
    endtask
    // an outside programmer takes the bus with the request pin
    task busReq(input lvl);
        busRequestInN = lvl;
    endtask
endmodule

//--- tb/processor_memory_map_decoder_bench.sv
/* self-checking bench for the memory map decoder with a decode model.
   assumes the requester model and monitor files are compiled first. */
`timescale 1ns/100ps
module processor_memory_map_decoder_bench;
    reg mclk, resetn, ce, dCacheEnA, dCacheEnB, iCacheEn, bootRom;
    reg [1:0] sdramSizeSel;
    wire reqValid, reqWrite, reqSuper, reqDma, reqFetch, busRequestInN;
    wire ackValid, ackError, sdramRowHit, busGranted;
    wire [31:0] reqAddr, bootVector, accessAddr;
    wire [8:0] selTarget;
    wire [3:0] asyncBankSelN;
    wire [1:0] busWidthBytes;
    integer err_count, samples_checked, seed, i, j, k;
    reg [31:0] r, pa, qa;
    reg [9:0] pe;
    reg [3:0] pb, qf;
    reg pv, ph, qv;
    reg [3:0] ov;
    reg [12:0] orow [0:3];
    reg [31:0] tb [0:22] = '{32'h0, 32'h00ffffff, 32'h01000000, 32'h1fffffff,
        32'h20000000, 32'h200ffffe, 32'h20100000, 32'h20300000, 32'h203fffff,
        32'h20400000, 32'hff7fffff, 32'hff800000, 32'hff804000, 32'hff808000,
        32'hff904000, 32'hffa10000, 32'hffa13ffc, 32'hffa14000, 32'hffb00ffc,
        32'hffb01000, 32'hffc00000, 32'hffe00000, 32'hffffffff};
    requester_model requester_model_inst (.reqValid, .reqAddr, .reqWrite, .reqSuper,
        .reqDma, .reqFetch, .busRequestInN);
    mem_map_decoder mem_map_decoder_inst (.mclk, .resetn, .ce, .reqValid, .reqAddr,
        .reqWrite, .reqSuper, .reqDma, .reqFetch, .sdramSizeSel, .dCacheEnA, .dCacheEnB,
        .iCacheEn, .bootRom, .busRequestInN, .ackValid, .ackError, .selTarget,
        .asyncBankSelN, .sdramRowHit, .busWidthBytes, .busGranted, .bootVector, .accessAddr);
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    // decode model: bit 9 is refusal, bits 8..0 the one-hot target
    function [9:0] dec(input [31:0] a, input s, input d, input f);
        reg [31:0] sz;
        begin
            sz = 32'h01000000 << (sdramSizeSel == 2'h3 ? 5 : sdramSizeSel * 2 - sdramSizeSel / 2);
            dec = 10'h200;
            if (a < sz) dec = 10'h001;
            else if (a >= 32'h20000000 && a < 32'h20400000) dec = 10'h002;
            else if (a >= 32'hff800000 && a < (dCacheEnA ? 32'hff804000 : 32'hff808000)) dec = 10'h004;
            else if (a >= 32'hff900000 && a < (dCacheEnB ? 32'hff904000 : 32'hff908000)) dec = 10'h008;
            else if (a >= 32'hffa00000 && a < (iCacheEn ? 32'hffa10000 : 32'hffa14000)) dec = 10'h010;
            else if (a >= 32'hffb00000 && a < 32'hffb01000) dec = 10'h020;
            else if (a >= 32'hffe00000) dec = 10'h080;
            else if (a >= 32'hffc00000) dec = 10'h040;
            if ((dec & 10'h0c0) && (d || !s)) dec = 10'h200;
            if (f && !(dec & 10'h013)) dec = 10'h200;
        end
    endfunction
    task chk(input [31:0] g, input [31:0] x);
        begin
            samples_checked = samples_checked + 1;
            if (g !== x) begin
                err_count = err_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, x);
            end
        end
    endtask
    // one cycle: judge the queued request at the edge just passed, then queue the next
    task step(input v, input [31:0] a, input [3:0] f);
        begin
            @(negedge mclk);
            // ce low at that edge froze every output, so the old expectation stands
            if (ce) begin
                pv = qv;
                pe = dec(qa, qf[2], qf[1], qf[0]);
                ph = 1'b0;
                pb = pe == 10'h002 ? ~(4'h1 << qa[21:20]) : 4'hf;
                // refused accesses leave the forwarded address alone
                if (pv && !pe[9])
                    pa = qa;
                if (pv && pe == 10'h001) begin
                    ph = ov[qa[23:22]] && orow[qa[23:22]] == qa[21:9];
                    ov[qa[23:22]] = 1'b1;
                    orow[qa[23:22]] = qa[21:9];
                end
            end
            chk(ackValid, pv);
            if (pv) begin
                chk(ackError, pe[9]);
                chk(selTarget, pe[8:0]);
                chk(asyncBankSelN, pb);
                chk(sdramRowHit, ph);
            end
            chk(accessAddr, pa);
            chk(busWidthBytes, 2'h2);
            qv = v;
            qa = a;
            qf = f;
            requester_model_inst.put(v, a, f);
        end
    endtask
    task rst(input b);
        begin
            bootRom = b;
            resetn = 1'b0;
            repeat (5) @(negedge mclk);
            resetn = 1'b1;
            {ov, pv, qv} = 6'h0;
            pa = 32'h0;
            repeat (2) @(negedge mclk);
            chk(bootVector, b ? 32'hef000000 : 32'h20000000);
        end
    endtask
    task wrap_up;
        begin
            $display("comparisons %0d, mismatches %0d", samples_checked, err_count);
            if (err_count == 0 && samples_checked > 0)
                $display("All tests passed");
            else
                $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #2000000;
        err_count = err_count + 1;
        wrap_up;
    end
    // main sequence: every size with a random cache mix, boundaries back to back, then random
    initial begin
        {resetn, ce, dCacheEnA, dCacheEnB, iCacheEn, bootRom, sdramSizeSel} = 8'h40;
        {err_count, samples_checked, seed} = {32'h0, 32'h0, 32'h41f0};
        rst(1'b1);
        for (k = 0; k < 8; k = k + 1) begin
            step(1'b0, 32'h0, 4'h0);
            sdramSizeSel = k;
            r = $random(seed);
            {dCacheEnA, dCacheEnB, iCacheEn} = r[2:0];
            for (i = 0; i < 23; i = i + 1)
                for (j = 0; j < 16; j = j + 1)
                    step(1'b1, tb[i], j);
            repeat (64) begin
                r = $random(seed);
                step(1'b1, r[1] ? tb[r[6:2] % 23] + r[31:23] : r & 32'h00ffffff, r[10:7]);
            end
        end
        step(1'b0, 32'h0, 4'h0);
        $display("test address map done");
        ce = 1'b0;
        step(1'b0, 32'h0, 4'h0);
        step(1'b1, 32'h20100000, 4'h4);
        step(1'b0, 32'h0, 4'h0);
        ce = 1'b1;
        step(1'b0, 32'h0, 4'h0);
        $display("test clock enable done");
        requester_model_inst.busReq(1'b0);
        repeat (8) @(negedge mclk);
        chk(busGranted, 1'b1);
        // external access while the pins are taken is dropped; internal ones still go
        requester_model_inst.put(1'b1, 32'h00000100, 4'h4);
        @(negedge mclk);
        chk(ackValid, 1'b0);
        requester_model_inst.put(1'b1, 32'hffb00000, 4'h4);
        @(negedge mclk);
        chk(ackValid, 1'b1);
        chk(selTarget, 9'h020);
        chk(busGranted, 1'b0);
        requester_model_inst.put(1'b0, 32'h0, 4'h0);
        requester_model_inst.busReq(1'b1);
        repeat (8) @(negedge mclk);
        chk(busGranted, 1'b0);
        $display("test bus request done");
        rst(1'b0);
        for (i = 0; i < 23; i = i + 1)
            step(1'b1, tb[i], 4'h4);
        step(1'b0, 32'h0, 4'h0);
        $display("test second reset done");
        wrap_up;
    end
endmodule
